// >>> hw/crc_pkg.sv
package crc_pkg;
  // Register byte offsets.
  localparam logic [7:0] CRC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CRC_OFF_SET1   = 8'h04;
  localparam logic [7:0] CRC_OFF_SET2   = 8'h08;
  localparam logic [7:0] CRC_OFF_STATUS = 8'h0c;
  localparam logic [7:0] CRC_OFF_PV1    = 8'h10;
  localparam logic [7:0] CRC_OFF_PV2    = 8'h14;
  localparam logic [7:0] CRC_OFF_AUX    = 8'h18;
  localparam logic [7:0] CRC_OFF_MEAS1  = 8'h1c;
  localparam logic [7:0] CRC_OFF_MEAS2  = 8'h20;
  // Control register field positions.
  localparam int CRC_CTRL_CFG_LSB   = 0;
  localparam int CRC_CTRL_DIR_LSB   = 3;
  localparam int CRC_CTRL_TWO_STAGE = 5;
  localparam int CRC_CTRL_WIDTH20   = 6;
  localparam int CRC_CTRL_INMODE    = 7;
  localparam int CRC_CTRL_OMODE     = 9;
  localparam logic [31:0] CRC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CRC_SET_RESET  = 32'h0000_0064;
  localparam logic [31:0] CRC_ZERO       = 32'h0000_0000;
  // Configurations.
  typedef enum logic [2:0] {
    CRC_CFG_PRESET = 3'b000,
    CRC_CFG_TOTAL  = 3'b001,
    CRC_CFG_BATCH  = 3'b010,
    CRC_CFG_DUAL   = 3'b011,
    CRC_CFG_TWIN   = 3'b100,
    CRC_CFG_TACHO  = 3'b101
  } crc_cfg_t;
  // Counting directions.
  typedef enum logic [1:0] {
    CRC_DIR_UP   = 2'b00,
    CRC_DIR_DOWN = 2'b01,
    CRC_DIR_UD   = 2'b10
  } crc_dir_t;
  // Tachometer input modes.
  typedef enum logic [1:0] {
    CRC_IN_SINGLE = 2'b00,
    CRC_IN_DIFF   = 2'b01,
    CRC_IN_INDEP  = 2'b10
  } crc_inmode_t;
  // Minimum reset widths and their output delays.
  localparam int CRC_CLK_MHZ      = 100;
  localparam int CRC_WIDTH_SHORT_US = 1000;
  localparam int CRC_WIDTH_LONG_US  = 20000;
  localparam int CRC_CYC_SHORT    = CRC_WIDTH_SHORT_US * CRC_CLK_MHZ;
  localparam int CRC_CYC_LONG     = CRC_WIDTH_LONG_US * CRC_CLK_MHZ;
  localparam int CRC_QCNT_W       = 22;
endpackage

// >>> hw/crc_qual_if.sv
`timescale 1ns/10ps
// Carries raw reset levels in and qualified levels out of the width qualifier.
interface crc_qual_if;
  logic raw_first;
  logic raw_second;
  logic long_width;
  logic ok_first;
  logic ok_second;
  modport qual (input raw_first, raw_second, long_width, output ok_first, ok_second);
  modport user (output raw_first, raw_second, long_width, input ok_first, ok_second);
endinterface

// >>> hw/crc_qual.sv
`timescale 1ns/10ps
// Synchronises both reset inputs and qualifies them against the minimum width.
module crc_qual #(
  parameter int unsigned CYC_SHORT = 100000,  // Cycles for the short width.
  parameter int unsigned CYC_LONG  = 2000000  // Cycles for the long width.
) (
  input wire logic  clk,    // System clock.
  input wire logic  reset,  // Synchronous reset.
  input wire logic  ce,     // Clock enable.
  crc_qual_if.qual  q       // Raw and qualified levels.
);
  import crc_pkg::*;
  typedef struct packed {
    logic [1:0]            s1;
    logic [1:0]            s2;
    logic [CRC_QCNT_W-1:0] c1;
    logic [CRC_QCNT_W-1:0] c2;
    logic                  ok1;
    logic                  ok2;
  } crc_qst_t;
  crc_qst_t st_reg;
  crc_qst_t st_next;
  logic [CRC_QCNT_W-1:0] limit;

  // A level counts toward qualification only after two flops; drops at once.
  always_comb begin
    limit = q.long_width ? CYC_LONG[CRC_QCNT_W-1:0] : CYC_SHORT[CRC_QCNT_W-1:0];
    st_next = st_reg;
    st_next.s1 = {st_reg.s1[0], q.raw_first};   // R18
    st_next.s2 = {st_reg.s2[0], q.raw_second};  // R18
    if (!st_reg.s1[1]) begin
      st_next.c1 = '0;
      st_next.ok1 = 1'b0;
    end else if (st_reg.c1 >= limit - 1'b1) begin
      st_next.ok1 = 1'b1;  // R18
    end else begin
      st_next.c1 = st_reg.c1 + 1'b1;
    end
    if (!st_reg.s2[1]) begin
      st_next.c2 = '0;
      st_next.ok2 = 1'b0;
    end else if (st_reg.c2 >= limit - 1'b1) begin
      st_next.ok2 = 1'b1;  // R18
    end else begin
      st_next.c2 = st_reg.c2 + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign q.ok_first = st_reg.ok1;
  assign q.ok_second = st_reg.ok2;

  a_qual_drop: assert property (@(posedge clk) disable iff (reset)
    ce && !st_reg.s1[1] |=> !st_reg.ok1)  // R18
    else $error("Qualified reset did not drop with its input.");
endmodule

// >>> hw/crc_top.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
// Overview of operation
// R1 - Primary reset clears present value in up or up/down counting.
// R2 - Primary reset in down counting loads set value, or set value 2 if two-stage.
// R3 - Reset indicator stays dark when only secondary reset is active; the tachometer in independent mode lights it on the secondary reset alone.
// R4 - Preset configurations ignore the secondary reset.
// R5 - Total-and-preset: secondary reset clears and holds total count at zero.
// R6 - Batch: secondary reset clears batch count and first output.
// R7 - Batch: batch count held at zero while secondary reset asserted.
// R8 - Dual: secondary reset clears second channel and blocks its counting.
// R9 - Twin: secondary reset clears second channel present value.
// R10 - Outputs turn off after the chosen minimum reset width.
// R11 - Tachometer accepts second input only outside single-input mode.
// R12 - Tachometer: primary reset freezes measurement and outputs.
// R13 - Tachometer: secondary reset holds channel two only in independent mode.
// R14 - Tachometer: reset indicator lit while a value is held.
// R15 - Outputs follow the output mode once set values are reached; only output one in preset/total and both in dual/twin use it.
// R16 - Non-dual counters suppress counting while primary reset asserted.
// R17 - Dual or twin: primary reset clears channel one and lights indicator.
// R18 - Reset inputs are synchronised and width-qualified before use.
// R19 - External source holds each reset at least the minimum width.
module crc_top #(
  parameter int unsigned CYC_SHORT = crc_pkg::CRC_CYC_SHORT,  // Short reset width.
  parameter int unsigned CYC_LONG  = crc_pkg::CRC_CYC_LONG    // Long reset width.
) (
  input  wire logic        clk,                    // System clock, 100 MHz.
  input  wire logic        reset,                  // Synchronous reset, active high.
  input  wire logic        ce,                     // Clock enable; low freezes all.
  input  wire logic        count_pulse_first,      // First count input level.
  input  wire logic        count_pulse_second,     // Second count input level.
  input  wire logic        reset_in_first,         // Primary reset input.
  input  wire logic        reset_in_second,        // Secondary reset input.
  input  wire logic        psel,                   // APB select.
  input  wire logic        penable,                // APB enable.
  input  wire logic        pwrite,                 // APB direction.
  input  wire logic [7:0]  paddr,                  // APB byte address.
  input  wire logic [31:0] pwdata,                 // APB write data.
  output logic      [31:0] prdata,                 // APB read data.
  output logic             pready,                 // APB ready.
  output logic             pslverr,                // APB error.
  output logic             control_output_first,   // First control output.
  output logic             control_output_second,  // Second control output.
  output logic             reset_indicator         // Reset indicator lamp.
);
  import crc_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] set1;
    logic [31:0] set2;
    logic [31:0] pv1;
    logic [31:0] pv2;
    logic [31:0] aux;
    logic [31:0] meas1;
    logic [31:0] meas2;
    logic        cp1_d;
    logic        cp2_d;
    logic        o1;
    logic        o2;
    logic        lamp;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } crc_st_t;

  crc_st_t     st_reg;
  crc_st_t     st_next;
  crc_qual_if  qif ();
  crc_cfg_t    cfg;
  crc_dir_t    dir;
  crc_inmode_t inmode;
  logic        two_stage;
  logic        rst1;
  logic        rst2;
  logic        up1;
  logic        up2;
  logic        omode;
  logic        acc;
  logic        mapped;

  // Width qualifier for both reset inputs.
  crc_qual #(
    .CYC_SHORT (CYC_SHORT),
    .CYC_LONG  (CYC_LONG)
  ) u_qual (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .q     (qif.qual)
  );

  // Raw levels into the qualifier; width selection from software.
  assign qif.raw_first  = reset_in_first;
  assign qif.raw_second = reset_in_second;
  assign qif.long_width = st_reg.ctrl[CRC_CTRL_WIDTH20];  // R10
  assign rst1 = qif.ok_first;
  assign rst2 = qif.ok_second;

  // Control field decode.
  assign cfg       = crc_cfg_t'(st_reg.ctrl[CRC_CTRL_CFG_LSB +: 3]);
  assign dir       = crc_dir_t'(st_reg.ctrl[CRC_CTRL_DIR_LSB +: 2]);
  assign inmode    = crc_inmode_t'(st_reg.ctrl[CRC_CTRL_INMODE +: 2]);
  assign two_stage = st_reg.ctrl[CRC_CTRL_TWO_STAGE];
  assign omode     = st_reg.ctrl[CRC_CTRL_OMODE];
  assign up1       = count_pulse_first & ~st_reg.cp1_d;
  assign up2       = count_pulse_second & ~st_reg.cp2_d;
  assign acc       = psel & penable;
  assign mapped    = (paddr[1:0] == 2'b00) && (paddr <= CRC_OFF_MEAS2);

  // Output level for a value against its set value; mode 1 holds until reset.
  function automatic logic crc_reach(input logic [31:0] v, input logic [31:0] sv,
                                     input logic hold, input logic prev, input logic m);
    crc_reach = (v >= sv) | (m & prev & ~hold);
  endfunction

  // Whole next state: counting, reset handling and the APB slave.
  always_comb begin
    st_next = st_reg;
    st_next.cp1_d = count_pulse_first;
    st_next.cp2_d = count_pulse_second;
    st_next.rdy = 1'b0;
    st_next.err = 1'b0;
    st_next.lamp = 1'b0;
    unique case (cfg)
      CRC_CFG_TACHO: begin
        // Measurement accumulates pulses; reset freezes the value and outputs.
        st_next.lamp = rst1 | (rst2 && inmode == CRC_IN_INDEP);  // R14
        if (!rst1) begin  // R12
          st_next.meas1 = st_reg.meas1 + {31'h0, up1};
          st_next.o1 = st_reg.meas1 >= st_reg.set1;  // R15
        end
        if (!rst1 && !(rst2 && inmode == CRC_IN_INDEP)) begin  // R13
          if (inmode != CRC_IN_SINGLE) begin  // R11
            st_next.meas2 = st_reg.meas2 + {31'h0, up2};
          end
          st_next.o2 = st_reg.meas2 >= st_reg.set2;  // R15
        end
      end
      CRC_CFG_DUAL, CRC_CFG_TWIN: begin
        st_next.lamp = rst1;  // R3
        if (rst1) begin
          st_next.pv1 = CRC_ZERO;  // R17
          st_next.o1 = 1'b0;
        end else begin
          st_next.pv1 = st_reg.pv1 + {31'h0, up1};
          st_next.o1 = crc_reach(st_reg.pv1, st_reg.set1, 1'b0, st_reg.o1, omode);
        end
        if (rst2) begin
          st_next.pv2 = CRC_ZERO;  // R8 R9
          st_next.o2 = 1'b0;
        end else if (!(cfg == CRC_CFG_TWIN && rst1)) begin
          st_next.pv2 = st_reg.pv2 + {31'h0, up2};
          st_next.o2 = crc_reach(st_reg.pv2, st_reg.set2, 1'b0, st_reg.o2, omode);
        end
      end
      default: begin
        // Preset, total-and-preset and batch configurations.
        st_next.lamp = rst1;  // R3
        if (rst1) begin
          if (dir == CRC_DIR_DOWN) begin
            st_next.pv1 = two_stage ? st_reg.set2 : st_reg.set1;  // R2
          end else begin
            st_next.pv1 = CRC_ZERO;  // R1
          end
          st_next.o2 = 1'b0;  // R10
          if (cfg != CRC_CFG_BATCH) begin
            st_next.o1 = 1'b0;
          end
        end else begin  // R16
          if (dir == CRC_DIR_DOWN) begin
            st_next.pv1 = st_reg.pv1 - {31'h0, up1};
          end else if (dir == CRC_DIR_UD) begin
            st_next.pv1 = st_reg.pv1 + {31'h0, up1} - {31'h0, up2};
          end else begin
            st_next.pv1 = st_reg.pv1 + {31'h0, up1};
          end
          if (cfg != CRC_CFG_BATCH) begin
            st_next.o1 = crc_reach(st_reg.pv1, st_reg.set1, 1'b0, st_reg.o1, omode);
          end
          st_next.o2 = (dir == CRC_DIR_DOWN) ? (st_reg.pv1 == CRC_ZERO)
                                             : (st_reg.pv1 >= st_reg.set2);  // R15
          if (cfg != CRC_CFG_PRESET) begin
            st_next.aux = st_reg.aux + {31'h0, up1};
          end
        end
        if (cfg == CRC_CFG_BATCH && !rst2 && st_reg.aux >= st_reg.set1) begin
          st_next.o1 = 1'b1;  // R15
        end
        if (rst2 && cfg != CRC_CFG_PRESET) begin  // R4
          st_next.aux = CRC_ZERO;  // R5 R7
          if (cfg == CRC_CFG_BATCH) begin
            st_next.o1 = 1'b0;  // R6
          end
        end
      end
    endcase
    // APB slave, one wait state in the access phase; writes and reads at its first edge.
    if (acc && !st_reg.rdy) begin
      st_next.rdy = 1'b1;
      st_next.err = !mapped;
      st_next.rdata = CRC_ZERO;
      if (pwrite) begin
        if (paddr == CRC_OFF_CTRL) st_next.ctrl = pwdata;
        if (paddr == CRC_OFF_SET1) st_next.set1 = pwdata;
        if (paddr == CRC_OFF_SET2) st_next.set2 = pwdata;
      end else begin
        unique case (paddr)
          CRC_OFF_CTRL:   st_next.rdata = st_reg.ctrl;
          CRC_OFF_SET1:   st_next.rdata = st_reg.set1;
          CRC_OFF_SET2:   st_next.rdata = st_reg.set2;
          CRC_OFF_STATUS: st_next.rdata = {27'h0, rst2, rst1, st_reg.lamp,
                                           st_reg.o2, st_reg.o1};
          CRC_OFF_PV1:    st_next.rdata = st_reg.pv1;
          CRC_OFF_PV2:    st_next.rdata = st_reg.pv2;
          CRC_OFF_AUX:    st_next.rdata = st_reg.aux;
          CRC_OFF_MEAS1:  st_next.rdata = st_reg.meas1;
          CRC_OFF_MEAS2:  st_next.rdata = st_reg.meas2;
          default:        st_next.rdata = CRC_ZERO;
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.ctrl <= CRC_CTRL_RESET;
      st_reg.set1 <= CRC_SET_RESET;
      st_reg.set2 <= CRC_SET_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign prdata                = st_reg.rdata;
  assign pready                = st_reg.rdy;
  assign pslverr               = st_reg.err;
  assign control_output_first  = st_reg.o1;
  assign control_output_second = st_reg.o2;
  assign reset_indicator       = st_reg.lamp;

  a_down_load: assert property (@(posedge clk) disable iff (reset)
    ce && rst1 && cfg == CRC_CFG_PRESET && dir == CRC_DIR_DOWN && !two_stage
    |=> st_reg.pv1 == $past(st_reg.set1))  // R2
    else $error("Down reset did not load set value.");
  a_up_clear: assert property (@(posedge clk) disable iff (reset)
    ce && rst1 && cfg == CRC_CFG_TOTAL && dir != CRC_DIR_DOWN |=> st_reg.pv1 == 0)  // R1
    else $error("Up reset did not clear present value.");
  a_lamp_dark: assert property (@(posedge clk) disable iff (reset)
    ce && !rst1 && cfg != CRC_CFG_TACHO |=> !reset_indicator)  // R3
    else $error("Indicator lit by secondary reset.");
  a_total_hold: assert property (@(posedge clk) disable iff (reset)
    ce && rst2 && (cfg == CRC_CFG_TOTAL || cfg == CRC_CFG_BATCH) |=> st_reg.aux == 0)  // R5
    else $error("Total or batch count not held at zero.");
  a_batch_out: assert property (@(posedge clk) disable iff (reset)
    ce && rst2 && cfg == CRC_CFG_BATCH |=> !control_output_first)  // R6
    else $error("Batch output not cleared.");
  a_dual_clear: assert property (@(posedge clk) disable iff (reset)
    ce && rst2 && (cfg == CRC_CFG_DUAL || cfg == CRC_CFG_TWIN) |=> st_reg.pv2 == 0)  // R8
    else $error("Second channel not cleared.");
  a_tacho_freeze: assert property (@(posedge clk) disable iff (reset)
    ce && rst1 && cfg == CRC_CFG_TACHO |=> $stable(st_reg.meas1) && $stable(st_reg.o1))  // R12
    else $error("Tachometer value not frozen.");
  a_tacho_lamp: assert property (@(posedge clk) disable iff (reset)
    ce && rst1 && cfg == CRC_CFG_TACHO |=> reset_indicator)  // R14
    else $error("Indicator dark while holding.");
  a_ch1_clear: assert property (@(posedge clk) disable iff (reset)
    ce && rst1 && cfg == CRC_CFG_DUAL |=> st_reg.pv1 == 0 && reset_indicator)  // R17
    else $error("Channel one not cleared.");
  c_down_reset: cover property (@(posedge clk) rst1 && dir == CRC_DIR_DOWN);
  c_batch_rst2: cover property (@(posedge clk) rst2 && cfg == CRC_CFG_BATCH);
  c_tacho_hold: cover property (@(posedge clk) rst1 && cfg == CRC_CFG_TACHO);
endmodule

// >>> testbench/crc_sensor_model.sv
`timescale 1ns/10ps
// Stands in for the count sensors and reset contacts wired to the block.
module crc_sensor_model (
  input  wire logic clk,      // System clock.
  output logic      pulse_a,  // Level on the first count input.
  output logic      pulse_b,  // Level on the second count input.
  output logic      rst_a,    // Level on the primary reset contact.
  output logic      rst_b     // Level on the secondary reset contact.
);
  // All contacts rest open at power-up.
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
    rst_a   = 1'b0;
    rst_b   = 1'b0;
  end

  // Sends n rising edges on one input; gap sets the cycles spent at each level.
  task automatic pulses(input logic ch, input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      if (ch) pulse_b <= 1'b1; else pulse_a <= 1'b1;
      repeat (gap) @(posedge clk);
      if (ch) pulse_b <= 1'b0; else pulse_a <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask

  // Closes or opens one reset contact just after an edge.
  task automatic contact(input logic ch, input logic v);
    @(posedge clk);
    if (ch) rst_b <= v; else rst_a <= v;
  endtask
endmodule

// >>> testbench/crc_top_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the reset handling of the counter block.
module crc_top_tb;
  import crc_pkg::*;
  localparam int unsigned CS    = 8;
  localparam int unsigned CL    = 20;
  localparam int          LIMIT = 20000;
  logic        clk, reset, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, b;
  logic        out_a, out_b, lamp, cp_a, cp_b, rs_a, rs_b;
  int          failures, tests_run, cycles, seed, width, n, m;

  crc_top #(.CYC_SHORT(CS), .CYC_LONG(CL)) u_crc_top (
    .clk(clk), .reset(reset), .ce(ce), .count_pulse_first(cp_a), .count_pulse_second(cp_b),
    .reset_in_first(rs_a), .reset_in_second(rs_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .control_output_first(out_a), .control_output_second(out_b),
    .reset_indicator(lamp));
  crc_sensor_model u_crc_sensor_model (
    .clk(clk), .pulse_a(cp_a), .pulse_b(cp_b), .rst_a(rs_a), .rst_b(rs_b));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Draws a repeatable value between lo and hi.
  function automatic int rnd(input int lo, input int hi);
    return lo + int'($unsigned($random(seed)) % (hi - lo + 1));
  endfunction

  // Counts a comparison and reports it when it differs.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Look at pready where it has settled; it stands until the next rising edge.
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) failures++;
    rv = prdata;
    err = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Closes a reset contact long enough to be qualified, or opens it again.
  task automatic hold(input logic ch);
    u_crc_sensor_model.contact(ch, 1'b1);
    repeat (width + 8) @(posedge clk);
  endtask
  task automatic free(input logic ch);
    u_crc_sensor_model.contact(ch, 1'b0);
    repeat (8) @(posedge clk);
  endtask
  task automatic cnt(input logic ch, input int k);
    u_crc_sensor_model.pulses(ch, k, rnd(2, 3));
    repeat (4) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      print_verdict();
    end
  end

  // Main sequence.
  initial begin
    reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; seed = 8070; width = CS;
    failures = 0; tests_run = 0; cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    apb(0, CRC_OFF_CTRL, 0); chk("ctrl", CRC_CTRL_RESET, rv);
    apb(0, CRC_OFF_SET1, 0); chk("set1", CRC_SET_RESET, rv);
    apb(0, CRC_OFF_SET2, 0); chk("set2", CRC_SET_RESET, rv);
    apb(0, 8'h24, 0); chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", CRC_ZERO, rv);
    apb(1, 8'h06, 32'h5); chk("misaligned err", 32'h1, {31'h0, err});
    // Preset, counting up: output at the set value, reset clears and blocks counting.
    n = rnd(3, 9);
    apb(1, CRC_OFF_SET1, 32'(n));
    hold(0); free(0);
    cnt(0, n); chk("control_output_first at set", 32'h1, {31'h0, out_a});
    hold(0); apb(0, CRC_OFF_PV1, 0); chk("pv1 up reset", CRC_ZERO, rv);
    chk("control_output_first after reset", 32'h0, {31'h0, out_a});
    cnt(0, 3); apb(0, CRC_OFF_PV1, 0); chk("pv1 blocked", CRC_ZERO, rv);
    free(0);
    cnt(0, 2); apb(0, CRC_OFF_PV1, 0); b = rv;
    hold(1); chk("lamp rst2", 32'h0, {31'h0, lamp});
    apb(0, CRC_OFF_PV1, 0); chk("pv1 rst2 preset", b, rv);
    free(1);
    // Up/down counting clears to zero; down counting loads a set value.
    apb(1, CRC_OFF_CTRL, 32'h10); cnt(0, rnd(2, 6)); cnt(1, 1);
    hold(0); apb(0, CRC_OFF_PV1, 0); chk("pv1 ud reset", CRC_ZERO, rv); free(0);
    for (int ts = 0; ts < 2; ts++) begin
      n = rnd(1, 200); m = rnd(1, 200);
      apb(1, CRC_OFF_SET1, 32'(n)); apb(1, CRC_OFF_SET2, 32'(m));
      apb(1, CRC_OFF_CTRL, 32'h8 | (32'(ts) << 5));
      hold(0); apb(0, CRC_OFF_PV1, 0); chk("pv1 down", 32'(ts ? m : n), rv); free(0);
    end
    // Pulses shorter than the chosen width are ignored, both widths.
    apb(1, CRC_OFF_CTRL, 32'h0); hold(0); free(0); n = rnd(1, 5); cnt(0, n);
    u_crc_sensor_model.contact(0, 1'b1); repeat (CS - 3) @(posedge clk); free(0);
    apb(0, CRC_OFF_PV1, 0); chk("pv1 short", 32'(n), rv);
    apb(1, CRC_OFF_CTRL, 32'h40); width = CL;
    u_crc_sensor_model.contact(0, 1'b1); repeat (CS + 4) @(posedge clk); free(0);
    apb(0, CRC_OFF_PV1, 0); chk("pv1 long width", 32'(n), rv);
    hold(0); apb(0, CRC_OFF_PV1, 0); chk("pv1 20ms", CRC_ZERO, rv); free(0);
    width = CS;
    // Total and batch: the auxiliary count is forced to zero by the second reset.
    apb(1, CRC_OFF_SET1, 32'h1);
    for (int c = 1; c < 3; c++) begin
      apb(1, CRC_OFF_CTRL, 32'(c)); cnt(0, rnd(2, 5)); hold(1);
      apb(0, CRC_OFF_AUX, 0); chk("aux cleared", CRC_ZERO, rv);
      if (c == 2) chk("batch control_output_first", 32'h0, {31'h0, out_a});
      cnt(0, 3); apb(0, CRC_OFF_AUX, 0); chk("aux held", CRC_ZERO, rv);
      chk("lamp aux", 32'h0, {31'h0, lamp}); free(1);
    end
    // Dual and twin: second reset clears channel two; primary clears channel one in dual.
    apb(1, CRC_OFF_CTRL, 32'h3); apb(1, CRC_OFF_SET2, 32'h1);
    apb(0, CRC_OFF_PV2, 0); b = rv; m = rnd(1, 6); cnt(1, m);
    apb(0, CRC_OFF_PV2, 0); chk("pv2 count", b + 32'(m), rv);
    chk("control_output_second at set", 32'h1, {31'h0, out_b});
    hold(1); apb(0, CRC_OFF_PV2, 0); chk("pv2 dual", CRC_ZERO, rv);
    chk("control_output_second dual rst2", 32'h0, {31'h0, out_b});
    cnt(1, 2); apb(0, CRC_OFF_PV2, 0); chk("pv2 blocked", CRC_ZERO, rv); free(1);
    hold(0); apb(0, CRC_OFF_PV1, 0); chk("pv1 dual", CRC_ZERO, rv);
    chk("lamp dual", 32'h1, {31'h0, lamp}); free(0);
    apb(1, CRC_OFF_CTRL, 32'h4); cnt(1, rnd(1, 6));
    hold(1); apb(0, CRC_OFF_PV2, 0); chk("pv2 twin", CRC_ZERO, rv); free(1);
    // Tachometer: inputs by mode, primary and secondary resets hold values.
    apb(1, CRC_OFF_CTRL, 32'h5); apb(0, CRC_OFF_MEAS2, 0); b = rv; cnt(1, 3);
    apb(0, CRC_OFF_MEAS2, 0); chk("meas2 single", b, rv);
    hold(0); chk("lamp hold", 32'h1, {31'h0, lamp});
    apb(0, CRC_OFF_MEAS1, 0); b = rv; cnt(0, 3);
    apb(0, CRC_OFF_MEAS1, 0); chk("meas1 held", b, rv); free(0);
    apb(1, CRC_OFF_CTRL, 32'h105); apb(0, CRC_OFF_MEAS2, 0); b = rv; m = rnd(1, 6); cnt(1, m);
    apb(0, CRC_OFF_MEAS2, 0); chk("meas2 indep", b + 32'(m), rv);
    hold(1); chk("lamp hold2", 32'h1, {31'h0, lamp});
    apb(0, CRC_OFF_MEAS2, 0); b = rv; cnt(1, 2);
    apb(0, CRC_OFF_MEAS2, 0); chk("meas2 held", b, rv); free(1);
    apb(1, CRC_OFF_CTRL, 32'h85); hold(1);
    chk("lamp diff rst2", 32'h0, {31'h0, lamp}); free(1);
    print_verdict();
  end
endmodule
